/* File: rtl/i2c_remap_consts.svh */
// offsets, field positions, reset values and timing counts of the control channel block
`ifndef I2C_REMAP_CONSTS_SVH
`define I2C_REMAP_CONSTS_SVH

`define CLK_PERIOD_NS 4
`define OFS_LINK_CTRL 8'h05
`define OFS_DESER_ADDR 8'h06
`define OFS_TARGET_PHYS0 8'h07
`define OFS_TARGET_ALIAS0 8'h08
`define RST_LINK_CTRL 5'h00
`define RST_ADDR7 7'h00
// control register fields
`define CTL_WD_DISABLE 0
`define CTL_WD_SPEEDUP 1
`define CTL_WR_BLOCK 2
`define CTL_SDA_DLY_LO 3
`define CTL_SDA_DLY_HI 4
// sda output delay: base plus steps
`define SDA_DLY_BASE_NS 240
`define SDA_DLY_STEP_NS 40
`define SDA_DLY_BASE_CYC ((`SDA_DLY_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SDA_DLY_STEP_CYC ((`SDA_DLY_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// watchdog intervals
`define WDOG_LONG_US 1000000
`define WDOG_SHORT_US 50
`define WDOG_LONG_CYC (`WDOG_LONG_US * 1000 / `CLK_PERIOD_NS)
`define WDOG_SHORT_CYC (`WDOG_SHORT_US * 1000 / `CLK_PERIOD_NS)
// bus clearing: nine pulses at 100 kHz
`define BUS_CLR_PULSES 9
`define BUS_CLR_HALF_NS 5000
`define BUS_CLR_HALF_CYC (`BUS_CLR_HALF_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/i2c_remap_pkg.sv */
// types shared by the control channel block
package i2c_remap_pkg;
    typedef enum logic [1:0] {
        WD_WATCH = 2'b00,
        WD_FREE = 2'b01,
        WD_CLEAR = 2'b10
    } wd_state_t;
endpackage

/* File: rtl/bit_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // refuse widths the flops cannot hold
    generate
        if (W < 1) begin : g_chk
            $error("bit_sync needs W of at least 1");
        end
    endgenerate

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* File: rtl/word_xfer.sv */
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module word_xfer #(
    parameter int W = 8
) (
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_valid,
    input wire logic [W-1:0] src_data,
    output logic src_ready,
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_valid,
    output logic [W-1:0] dst_data
);
    logic req_q, ack_s, req_s, seen_q;
    logic [W-1:0] hold_q;
    wire new_word = req_s ^ seen_q;

    generate
        if (W < 1) begin : g_chk
            $error("word_xfer needs W of at least 1");
        end
    endgenerate

    // source keeps the word stable until the ack toggle returns
    assign src_ready = (req_q == ack_s);
    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            req_q <= 1'b0;
            hold_q <= '0;
        end else if (src_valid && src_ready) begin
            req_q <= ~req_q;
            hold_q <= src_data;
        end
    end

    bit_sync #(.W(1)) u_req (.clk(dst_clk), .rst(dst_rst), .d(req_q), .q(req_s));
    bit_sync #(.W(1)) u_ack (.clk(src_clk), .rst(src_rst), .d(seen_q), .q(ack_s));

    // destination takes the word once the request toggle has settled
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            seen_q <= 1'b0;
            dst_valid <= 1'b0;
            dst_data <= '0;
        end else begin
            seen_q <= req_s;
            dst_valid <= new_word;
            if (new_word) begin
                dst_data <= hold_q;
            end
        end
    end
endmodule

/* File: rtl/i2c_ctrl_remap.sv */
// control channel i2c block: sda delay, write block, bus watchdog, address remap
`timescale 1ns/1ps
`include "i2c_remap_consts.svh"

// Contract
// - sda output delay grows by 40ns per step of control bits 4:3
// - delay field 00,01,10,11 gives 240,280,320,360ns; resets to 00
// - control bit 2 set refuses far-end writes to local registers
// - write block never stops far-end access to local i2c targets
// - bus watchdog runs unless control bit 0 is set
// - watchdog expires after 1 s, or 50 us with speed-up bit 1
// - sda high and quiet until expiry marks the bus free
// - sda low and quiet until expiry drives nine scl pulses
// - deserializer address in bits 7:1; zero disables access to it
// - deserializer address loads automatically when the link reports lock
// - physical address of the far target kept in bits 7:1
// - alias-addressed transactions are forwarded with the physical address
// - alias in bits 7:1 drives the decoder; zero disables the target
module i2c_ctrl_remap
    import i2c_remap_pkg::*;
#(
    parameter int unsigned WDOG_LONG_CYC = `WDOG_LONG_CYC,
    parameter int unsigned WDOG_SHORT_CYC = `WDOG_SHORT_CYC,
    parameter int unsigned CLR_HALF_CYC = `BUS_CLR_HALF_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic HOLD_FAR_ADDR,
    input wire logic SDA_DRIVE_LOW,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OE,
    output logic SCL_OE,
    output logic BUS_FREE,
    input wire logic ADDR_VALID,
    input wire logic [6:0] ADDR_IN,
    input wire logic ADDR_RNW,
    output logic FWD_MISS,
    output logic REM_WR_REFUSED,
    input wire logic LINK_CLK,
    input wire logic LINK_RST,
    input wire logic RX_LOCK,
    input wire logic [6:0] LINK_DES_ADDR,
    input wire logic REM_WR,
    input wire logic [7:0] REM_ADDR,
    input wire logic [7:0] REM_WDATA,
    output logic FWD_VALID,
    output logic [7:0] FWD_ADDR
);
    generate
        if (WDOG_SHORT_CYC < 2 || WDOG_LONG_CYC < 2 || WDOG_LONG_CYC >= 2**28 || CLR_HALF_CYC < 1
            || CLR_HALF_CYC >= 2**16) begin : g_chk
            $error("watchdog or clearing counts out of range");
        end
    endgenerate

    // register state
    logic [4:0] ctrl_q;
    logic [6:0] des_q, phys_q, alias_q;

    // far-end writes cross into the local domain, then wait for a free write slot
    logic rem_valid, rem_pend_q;
    logic [15:0] rem_word, rem_q;
    word_xfer #(.W(16)) u_rem (
        .src_clk(LINK_CLK), .src_rst(LINK_RST), .src_valid(REM_WR), .src_data({REM_ADDR, REM_WDATA}),
        .src_ready(), .dst_clk(CLK), .dst_rst(SRST), .dst_valid(rem_valid), .dst_data(rem_word)
    );

    // lock rising edge sends the learned deserializer address across
    logic lock_q, lock_valid;
    logic [6:0] lock_addr;
    always_ff @(posedge LINK_CLK) begin
        if (LINK_RST) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= RX_LOCK;
        end
    end
    word_xfer #(.W(7)) u_lock (
        .src_clk(LINK_CLK), .src_rst(LINK_RST), .src_valid(RX_LOCK && !lock_q), .src_data(LINK_DES_ADDR),
        .src_ready(), .dst_clk(CLK), .dst_rst(SRST), .dst_valid(lock_valid), .dst_data(lock_addr)
    );

    // write port selection: local first, far end when the local port is idle
    wire rem_go = rem_pend_q && !REG_WR;
    wire rem_ok = rem_go && !ctrl_q[`CTL_WR_BLOCK];
    wire wr_en = REG_WR || rem_ok;
    wire [7:0] wr_addr = REG_WR ? REG_ADDR : rem_q[15:8];
    wire [7:0] wr_data = REG_WR ? REG_WDATA : rem_q[7:0];
    wire wr_ctrl = wr_en && (wr_addr == `OFS_LINK_CTRL);
    wire wr_des = wr_en && (wr_addr == `OFS_DESER_ADDR);
    wire wr_phys = wr_en && (wr_addr == `OFS_TARGET_PHYS0);
    wire wr_alias = wr_en && (wr_addr == `OFS_TARGET_ALIAS0);
    wire lock_load = lock_valid && !HOLD_FAR_ADDR && !wr_des;

    // pending far-end write; a new arrival wins over the slot being used
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rem_pend_q <= 1'b0;
            rem_q <= 16'h0000;
        end else if (rem_valid) begin
            rem_pend_q <= 1'b1;
            rem_q <= rem_word;
        end else if (rem_go) begin
            rem_pend_q <= 1'b0;
        end
    end

    // register file; the block bit guards only these writes, not target access
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= `RST_LINK_CTRL;
            des_q <= `RST_ADDR7;
            phys_q <= `RST_ADDR7;
            alias_q <= `RST_ADDR7;
            REM_WR_REFUSED <= 1'b0;
        end else begin
            REM_WR_REFUSED <= rem_go && ctrl_q[`CTL_WR_BLOCK];
            if (wr_ctrl) begin
                ctrl_q <= wr_data[4:0];
            end
            if (wr_des) begin
                des_q <= wr_data[7:1];
            end else if (lock_load) begin
                des_q <= lock_addr;
            end
            if (wr_phys) begin
                phys_q <= wr_data[7:1];
            end
            if (wr_alias) begin
                alias_q <= wr_data[7:1];
            end
        end
    end

    // read mux, reserved bits read zero
    wire [7:0] rd_mux = (REG_ADDR == `OFS_LINK_CTRL) ? {3'h0, ctrl_q} :
                        (REG_ADDR == `OFS_DESER_ADDR) ? {des_q, 1'b0} :
                        (REG_ADDR == `OFS_TARGET_PHYS0) ? {phys_q, 1'b0} :
                        (REG_ADDR == `OFS_TARGET_ALIAS0) ? {alias_q, 1'b0} : 8'h00;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

    // address decode: alias remaps, deserializer passes, zero disables either
    wire alias_hit = (alias_q != 7'h00) && (ADDR_IN == alias_q);
    wire des_hit = (des_q != 7'h00) && (ADDR_IN == des_q);
    wire [6:0] fwd_addr7 = alias_hit ? phys_q : ADDR_IN;
    wire fwd_rdy;
    wire fwd_push = ADDR_VALID && (alias_hit || des_hit) && fwd_rdy;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FWD_MISS <= 1'b0;
        end else begin
            FWD_MISS <= ADDR_VALID && !fwd_push;
        end
    end
    word_xfer #(.W(8)) u_fwd (
        .src_clk(CLK), .src_rst(SRST), .src_valid(fwd_push), .src_data({fwd_addr7, ADDR_RNW}),
        .src_ready(fwd_rdy), .dst_clk(LINK_CLK), .dst_rst(LINK_RST), .dst_valid(FWD_VALID), .dst_data(FWD_ADDR)
    );

    // sda output delay: follow the request after the count of cycles selected by control bits 4:3
    logic [6:0] dly_cnt_q;
    wire [1:0] dly_sel = ctrl_q[`CTL_SDA_DLY_HI:`CTL_SDA_DLY_LO];
    wire [6:0] dly_cyc = 7'(`SDA_DLY_BASE_CYC) + 7'(`SDA_DLY_STEP_CYC) * {5'h00, dly_sel};
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SDA_OE <= 1'b0;
            dly_cnt_q <= 7'h00;
        end else if (SDA_DRIVE_LOW == SDA_OE) begin
            dly_cnt_q <= 7'h00;
        end else if (dly_cnt_q >= dly_cyc - 7'h01) begin
            SDA_OE <= SDA_DRIVE_LOW;
            dly_cnt_q <= 7'h00;
        end else begin
            dly_cnt_q <= dly_cnt_q + 7'h01;
        end
    end

    // bus pins pass two flip-flops before the watchdog looks at them
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    bit_sync #(.W(2)) u_pins (.clk(CLK), .rst(SRST), .d({SCL_IN, SDA_IN}), .q({scl_s, sda_s}));
    always_ff @(posedge CLK) begin
        if (SRST) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // watchdog state
    wd_state_t wd_state_q, wd_state_d;
    logic [27:0] wd_cnt_q, wd_cnt_d;
    logic [15:0] half_q, half_d;
    logic [3:0] pulse_n_q, pulse_n_d;
    logic scl_oe_d, free_d;
    wire activity = (scl_s ^ scl_p_q) || (sda_s ^ sda_p_q);
    wire wd_dis = ctrl_q[`CTL_WD_DISABLE];
    wire [27:0] wd_limit = ctrl_q[`CTL_WD_SPEEDUP] ? 28'(WDOG_SHORT_CYC) : 28'(WDOG_LONG_CYC);
    wire wd_expire = (wd_cnt_q >= wd_limit - 28'h1);
    wire half_end = (half_q >= 16'(CLR_HALF_CYC) - 16'h1);

    // watchdog next state: watch for quiet, mark free or clock the bus clear
    always_comb begin
        wd_state_d = wd_state_q;
        wd_cnt_d = wd_cnt_q;
        half_d = half_q;
        pulse_n_d = pulse_n_q;
        scl_oe_d = SCL_OE;
        free_d = BUS_FREE;
        case (wd_state_q)
            WD_WATCH: begin
                if (wd_dis || activity) begin
                    wd_cnt_d = 28'h0;
                end else if (wd_expire) begin
                    wd_cnt_d = 28'h0;
                    if (sda_s) begin
                        wd_state_d = WD_FREE;
                        free_d = 1'b1;
                    end else begin
                        wd_state_d = WD_CLEAR;
                        half_d = 16'h0;
                        pulse_n_d = 4'h0;
                    end
                end else begin
                    wd_cnt_d = wd_cnt_q + 28'h1;
                end
            end
            WD_FREE: begin
                if (wd_dis || activity) begin
                    wd_state_d = WD_WATCH;
                    free_d = 1'b0;
                end
            end
            WD_CLEAR: begin
                if (wd_dis) begin
                    wd_state_d = WD_WATCH;
                    scl_oe_d = 1'b0;
                end else if (pulse_n_q == 4'(`BUS_CLR_PULSES)) begin
                    wd_state_d = WD_WATCH;
                end else if (half_end) begin
                    half_d = 16'h0;
                    scl_oe_d = !SCL_OE;
                    if (SCL_OE) begin
                        pulse_n_d = pulse_n_q + 4'h1;
                    end
                end else begin
                    half_d = half_q + 16'h1;
                end
            end
            default: begin
                wd_state_d = WD_WATCH;
                scl_oe_d = 1'b0;
                free_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wd_state_q <= WD_WATCH;
            wd_cnt_q <= 28'h0;
            half_q <= 16'h0;
            pulse_n_q <= 4'h0;
            SCL_OE <= 1'b0;
            BUS_FREE <= 1'b0;
        end else begin
            wd_state_q <= wd_state_d;
            wd_cnt_q <= wd_cnt_d;
            half_q <= half_d;
            pulse_n_q <= pulse_n_d;
            SCL_OE <= scl_oe_d;
            BUS_FREE <= free_d;
        end
    end

    // checks on the local clock domain
    sda_delay_a: assert property (@(posedge CLK) disable iff (SRST)
        $changed(SDA_OE) |-> ($past(dly_cnt_q) + 7'h01 == $past(dly_cyc)) && SDA_OE == $past(SDA_DRIVE_LOW))
        else $error("sda output changed before its delay ran out");
    sda_base_a: assert property (@(posedge CLK) disable iff (SRST)
        (SDA_OE != $past(SDA_OE) && dly_sel == 2'b00) |-> $past(SDA_DRIVE_LOW, 60) == SDA_OE
        && $past(SDA_DRIVE_LOW, 61) != SDA_OE)
        else $error("default sda delay is not 240ns");
    wr_block_a: assert property (@(posedge CLK) disable iff (SRST)
        (rem_go && ctrl_q[`CTL_WR_BLOCK] && !lock_valid) |=> $stable(ctrl_q) && $stable(des_q)
        && $stable(phys_q) && $stable(alias_q) && REM_WR_REFUSED)
        else $error("blocked far-end write changed a register");
    wd_off_a: assert property (@(posedge CLK) disable iff (SRST)
        wd_dis |=> wd_cnt_q == 28'h0 && wd_state_q != WD_CLEAR)
        else $error("watchdog ran while disabled");
    wd_free_a: assert property (@(posedge CLK) disable iff (SRST)
        (wd_state_q == WD_WATCH && !wd_dis && !activity && wd_expire && sda_s) |=> BUS_FREE && !SCL_OE)
        else $error("quiet high bus not marked free");
    wd_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        (wd_state_q == WD_WATCH && !wd_dis && !activity && wd_expire && !sda_s) |=>
        wd_state_q == WD_CLEAR && pulse_n_q == 4'h0)
        else $error("quiet low bus not cleared");
    nine_pulses_a: assert property (@(posedge CLK) disable iff (SRST)
        (wd_state_q == WD_CLEAR && !wd_dis && wd_state_d == WD_WATCH) |-> pulse_n_q == 4'h9 && !SCL_OE)
        else $error("bus clear ended without nine pulses");
    wd_limit_a: assert property (@(posedge CLK) disable iff (SRST)
        (wd_state_q == WD_WATCH && $stable(wd_limit)) |-> wd_cnt_q < wd_limit)
        else $error("watchdog count passed its interval");
    alias_map_a: assert property (@(posedge CLK) disable iff (SRST)
        (fwd_push && alias_hit) |-> ##1 u_fwd.hold_q == {$past(phys_q), $past(ADDR_RNW)})
        else $error("alias not remapped to physical address");
    des_pass_a: assert property (@(posedge CLK) disable iff (SRST)
        (fwd_push && des_hit && !alias_hit) |-> ##1 u_fwd.hold_q == {$past(ADDR_IN), $past(ADDR_RNW)})
        else $error("deserializer address altered on forwarding");
    zero_off_a: assert property (@(posedge CLK) disable iff (SRST)
        (ADDR_VALID && ADDR_IN == 7'h00) |=> FWD_MISS)
        else $error("zero address was forwarded");
    lock_load_a: assert property (@(posedge CLK) disable iff (SRST)
        (lock_valid && !HOLD_FAR_ADDR && !wr_des) |=> des_q == $past(lock_addr))
        else $error("deserializer address not learned at lock");
endmodule

/* File: testbench/far_link_model.sv */
// far-end link model: lock report, far register writes, capture of forwarded addresses
`timescale 1ns/1ps
module far_link_model (
    input wire logic LINK_CLK,
    output logic RX_LOCK,
    output logic [6:0] LINK_DES_ADDR,
    output logic REM_WR,
    output logic [7:0] REM_ADDR,
    output logic [7:0] REM_WDATA,
    input wire logic FWD_VALID,
    input wire logic [7:0] FWD_ADDR
);
    logic [7:0] seen_addr = 8'h00;
    int seen_cnt = 0;
    initial begin
        RX_LOCK = 1'b0;
        LINK_DES_ADDR = 7'h2a;
        REM_WR = 1'b0;
        REM_ADDR = 8'h00;
        REM_WDATA = 8'h00;
    end
    // capture every forwarded address word
    always @(posedge LINK_CLK) begin
        if (FWD_VALID === 1'b1) begin
            seen_addr <= FWD_ADDR;
            seen_cnt <= seen_cnt + 1;
        end
    end
    // report lock with the address to learn, then drop lock and scramble the lines
    task automatic lock_pulse(input logic [6:0] a);
        @(posedge LINK_CLK);
        LINK_DES_ADDR <= a;
        @(posedge LINK_CLK);
        RX_LOCK <= 1'b1;
        repeat (12) @(posedge LINK_CLK);
        RX_LOCK <= 1'b0;
        LINK_DES_ADDR <= ~a;
        @(posedge LINK_CLK);
    endtask
    // one far register write, spaced well apart from the next
    task automatic rem_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge LINK_CLK);
        REM_WR <= 1'b1;
        REM_ADDR <= a;
        REM_WDATA <= d;
        @(posedge LINK_CLK);
        REM_WR <= 1'b0;
        REM_ADDR <= ~a;
        REM_WDATA <= ~d;
        repeat (10) @(posedge LINK_CLK);
    endtask
endmodule

/* File: testbench/i2c_ctrl_remap_tb_top.sv */
// self-checking bench for the control channel i2c block
`timescale 1ns/1ps
`include "i2c_remap_consts.svh"
module i2c_ctrl_remap_tb_top;
    logic CLK = 1'b0, LINK_CLK = 1'b0, SRST = 1'b1, LINK_RST = 1'b1;
    logic REG_WR = 1'b0, REG_RD = 1'b0, HOLD_FAR_ADDR = 1'b0, SDA_DRIVE_LOW = 1'b0;
    logic ADDR_VALID = 1'b0, ADDR_RNW = 1'b0, sda_low_tb = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, FWD_ADDR, REM_ADDR, REM_WDATA, rd, wv;
    logic [6:0] ADDR_IN = 7'h00, LINK_DES_ADDR, a7, p7, d7;
    logic SDA_OE, SCL_OE, BUS_FREE, FWD_MISS, REM_WR_REFUSED, FWD_VALID, RX_LOCK, REM_WR;
    int miscompares = 0, num_checks = 0, miss_cnt = 0, refuse_cnt = 0, pulses = 0, n, m, seed;
    // open-drain wires with pull-ups
    wire logic SCL_IN = ~SCL_OE;
    wire logic SDA_IN = ~(SDA_OE | sda_low_tb);
    always #2 CLK = ~CLK;
    always #15 LINK_CLK = ~LINK_CLK;
    i2c_ctrl_remap #(.WDOG_LONG_CYC(200), .WDOG_SHORT_CYC(50), .CLR_HALF_CYC(4)) i_dut (
        .CLK(CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .HOLD_FAR_ADDR(HOLD_FAR_ADDR),
        .SDA_DRIVE_LOW(SDA_DRIVE_LOW), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE),
        .SCL_OE(SCL_OE), .BUS_FREE(BUS_FREE), .ADDR_VALID(ADDR_VALID), .ADDR_IN(ADDR_IN),
        .ADDR_RNW(ADDR_RNW), .FWD_MISS(FWD_MISS), .REM_WR_REFUSED(REM_WR_REFUSED),
        .LINK_CLK(LINK_CLK), .LINK_RST(LINK_RST), .RX_LOCK(RX_LOCK), .LINK_DES_ADDR(LINK_DES_ADDR),
        .REM_WR(REM_WR), .REM_ADDR(REM_ADDR), .REM_WDATA(REM_WDATA), .FWD_VALID(FWD_VALID),
        .FWD_ADDR(FWD_ADDR));
    far_link_model i_far (.LINK_CLK(LINK_CLK), .RX_LOCK(RX_LOCK), .LINK_DES_ADDR(LINK_DES_ADDR),
        .REM_WR(REM_WR), .REM_ADDR(REM_ADDR), .REM_WDATA(REM_WDATA), .FWD_VALID(FWD_VALID),
        .FWD_ADDR(FWD_ADDR));
    // count miss, refusal and bus clear pulses
    always @(posedge CLK) begin
        if (FWD_MISS === 1'b1) miss_cnt++;
        if (REM_WR_REFUSED === 1'b1) refuse_cnt++;
    end
    always @(posedge SCL_OE) pulses++;
    // expected values
    function automatic logic [7:0] fwd_word(input logic [6:0] a, input logic r);
        return {a, r};
    endfunction
    function automatic int sda_cycles(input int f);
        return (`SDA_DLY_BASE_NS + `SDA_DLY_STEP_NS * f) / `CLK_PERIOD_NS;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // register access tasks
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(posedge CLK);
        #1 rd = REG_RDATA;
    endtask
    task automatic send_addr(input logic [6:0] a, input logic r);
        @(posedge CLK);
        ADDR_VALID <= 1'b1;
        ADDR_IN <= a;
        ADDR_RNW <= r;
        @(posedge CLK);
        ADDR_VALID <= 1'b0;
        repeat (60) @(posedge CLK);
    endtask
    task automatic wait_oe(input logic lvl);
        n = 0;
        while (SDA_OE !== lvl && n < 200) begin
            @(posedge CLK);
            #1 n++;
        end
    endtask
    task automatic bus_edge;
        @(posedge CLK);
        sda_low_tb <= 1'b1;
        @(posedge CLK);
        sda_low_tb <= 1'b0;
    endtask
    // hang guard
    initial begin
        #400000;
        miscompares++;
        $display("[FAIL] %0t run did not finish", $time);
        tally_and_finish();
    end
    // main sequence
    initial begin
        seed = $urandom(32'h63d6);
        fork
            begin
                repeat (3) @(posedge LINK_CLK);
                LINK_RST <= 1'b0;
            end
            begin
                repeat (5) @(posedge CLK);
                SRST <= 1'b0;
            end
        join
        reg_wr(8'h09, 8'hff);
        for (int i = 5; i <= 9; i++) begin
            reg_rd(8'(i));
            check(rd, 8'h00);
        end
        for (int i = 5; i <= 8; i++) begin
            wv = 8'($urandom);
            reg_wr(8'(i), wv);
            reg_rd(8'(i));
            check(rd, wv & ((i == 5) ? 8'h1f : 8'hfe));
        end
        $display("test registers done");
        // sda delay per field value, then a short glitch that must vanish
        for (int f = 0; f < 4; f++) begin
            reg_wr(8'h05, 8'(f << 3) | 8'h01);
            @(posedge CLK);
            SDA_DRIVE_LOW <= 1'b1;
            wait_oe(1'b1);
            check(8'(n), 8'(sda_cycles(f)));
            @(posedge CLK);
            SDA_DRIVE_LOW <= 1'b0;
            wait_oe(1'b0);
            check(8'(n), 8'(sda_cycles(f)));
        end
        @(posedge CLK);
        SDA_DRIVE_LOW <= 1'b1;
        repeat (5) @(posedge CLK);
        SDA_DRIVE_LOW <= 1'b0;
        wait_oe(1'b1);
        check(8'(n), 8'hc8);
        $display("test sda delay done");
        // watchdog: long and short interval, hung bus clearing, disable
        reg_wr(8'h05, 8'h00);
        bus_edge();
        repeat (190) @(posedge CLK);
        check(8'(BUS_FREE), 8'h00);
        repeat (25) @(posedge CLK);
        check(8'(BUS_FREE), 8'h01);
        reg_wr(8'h05, 8'h02);
        bus_edge();
        repeat (10) @(posedge CLK);
        check(8'(BUS_FREE), 8'h00);
        repeat (30) @(posedge CLK);
        check(8'(BUS_FREE), 8'h00);
        repeat (25) @(posedge CLK);
        check(8'(BUS_FREE), 8'h01);
        pulses = 0;
        @(posedge CLK);
        sda_low_tb <= 1'b1;
        repeat (140) @(posedge CLK);
        check(8'(pulses), 8'h09);
        check(8'(BUS_FREE), 8'h00);
        sda_low_tb <= 1'b0;
        repeat (70) @(posedge CLK);
        check(8'(BUS_FREE), 8'h01);
        reg_wr(8'h05, 8'h03);
        pulses = 0;
        repeat (5) @(posedge CLK);
        check(8'(BUS_FREE), 8'h00);
        sda_low_tb <= 1'b1;
        repeat (150) @(posedge CLK);
        sda_low_tb <= 1'b0;
        check(8'(pulses), 8'h00);
        $display("test watchdog done");
        // address learned at lock, held when frozen, then forwarding
        d7 = 7'($urandom_range(1, 63));
        a7 = 7'($urandom_range(64, 127));
        p7 = 7'($urandom);
        i_far.lock_pulse(d7);
        repeat (20) @(posedge CLK);
        reg_rd(8'h06);
        check(rd, {d7, 1'b0});
        @(posedge CLK);
        HOLD_FAR_ADDR <= 1'b1;
        i_far.lock_pulse(~d7);
        repeat (20) @(posedge CLK);
        reg_rd(8'h06);
        check(rd, {d7, 1'b0});
        @(posedge CLK);
        HOLD_FAR_ADDR <= 1'b0;
        reg_wr(8'h07, {p7, 1'b0});
        reg_wr(8'h08, {a7, 1'b0});
        for (int i = 0; i < 4; i++) begin
            n = i_far.seen_cnt;
            send_addr(i[1] ? d7 : a7, i[0]);
            check(8'(i_far.seen_cnt - n), 8'h01);
            check(i_far.seen_addr, fwd_word(i[1] ? d7 : p7, i[0]));
        end
        reg_wr(8'h06, 8'h00);
        reg_wr(8'h08, 8'h00);
        n = i_far.seen_cnt;
        m = miss_cnt;
        send_addr(a7, 1'b0);
        send_addr(d7, 1'b1);
        send_addr(7'h00, 1'b0);
        check(8'(miss_cnt - m), 8'h03);
        check(8'(i_far.seen_cnt - n), 8'h00);
        $display("test forwarding done");
        // far-end writes allowed by default, refused with the block bit
        wv = 8'($urandom) & 8'hfe;
        i_far.rem_write(8'h07, wv);
        repeat (20) @(posedge CLK);
        reg_rd(8'h07);
        check(rd, wv);
        reg_wr(8'h05, 8'h04);
        m = refuse_cnt;
        i_far.rem_write(8'h07, ~wv);
        repeat (20) @(posedge CLK);
        reg_rd(8'h07);
        check(rd, wv);
        check(8'(refuse_cnt - m), 8'h01);
        reg_wr(8'h08, {a7, 1'b0});
        n = i_far.seen_cnt;
        send_addr(a7, 1'b1);
        check(i_far.seen_addr, fwd_word(wv[7:1], 1'b1));
        $display("test far writes done");
        tally_and_finish();
    end
endmodule
